// *** rtl/comm_params_pkg.sv ***
// communication parameter bank: offsets, factory values, ranges, timing
// assumes a single 100 MHz clock domain for every user of these constants
package comm_params_pkg;
  localparam int unsigned DATA_W = 16;
  // modbus register addresses
  localparam logic [15:0] MB_NODE_ADDR = 16'h0400;
  localparam logic [15:0] MB_RATE = 16'h0402;
  localparam logic [15:0] MB_CONN = 16'h0404;
  localparam logic [15:0] MB_FAULT = 16'h0406;
  localparam logic [15:0] MB_TIMEOUT = 16'h0408;
  localparam logic [15:0] MB_CO_ADDR = 16'h040A;
  localparam logic [15:0] MB_FORCE = 16'h040C;
  localparam logic [15:0] MB_DELAY = 16'h040E;
  localparam logic [15:0] MB_SYNC = 16'h0412;
  localparam logic [15:0] MB_PROFILE = 16'h0414;
  // canopen object indices
  localparam logic [15:0] CO_NODE_ADDR = 16'h4300;
  localparam logic [15:0] CO_RATE = 16'h4301;
  localparam logic [15:0] CO_CONN = 16'h4302;
  localparam logic [15:0] CO_FAULT = 16'h4303;
  localparam logic [15:0] CO_TIMEOUT = 16'h4304;
  localparam logic [15:0] CO_CO_ADDR = 16'h4305;
  localparam logic [15:0] CO_FORCE = 16'h4306;
  localparam logic [15:0] CO_DELAY = 16'h4307;
  localparam logic [15:0] CO_SYNC = 16'h4309;
  localparam logic [15:0] CO_PROFILE = 16'h430A;
  // factory values
  localparam logic [15:0] RST_NODE_ADDR = 16'h007F;
  localparam logic [15:0] RST_RATE = 16'h0102;
  localparam logic [15:0] RST_CONN = 16'h0007;
  localparam logic [15:0] RST_FAULT = 16'h0000;
  localparam logic [15:0] RST_TIMEOUT = 16'h0000;
  localparam logic [15:0] RST_CO_ADDR = 16'h0000;
  localparam logic [15:0] RST_FORCE = 16'h0000;
  localparam logic [15:0] RST_DELAY = 16'h0000;
  localparam logic [15:0] RST_SYNC = 16'h5055;
  localparam logic [15:0] RST_PROFILE = 16'h0000;
  // accepted ranges
  localparam logic [15:0] MIN_NODE_ADDR = 16'h0001;
  localparam logic [15:0] MAX_NODE_ADDR = 16'h00F7;
  localparam logic [15:0] MAX_RATE = 16'h0405;
  localparam logic [15:0] MIN_CONN = 16'h0006;
  localparam logic [15:0] MAX_CONN = 16'h0009;
  localparam logic [15:0] MAX_FLAG = 16'h0001;
  localparam logic [15:0] MAX_TIMEOUT = 16'h4E20;
  localparam logic [15:0] MAX_CO_ADDR = 16'h007F;
  localparam logic [15:0] MAX_FORCE = 16'h07FF;
  localparam logic [15:0] MAX_DELAY = 16'h03E8;
  localparam logic [15:0] MIN_SYNC = 16'h1001;
  localparam logic [15:0] MAX_SYNC = 16'h9FFF;
  // canopen share of the transmission rate word, and forcing width
  localparam int unsigned RATE_CO_LSB = 8;
  localparam int unsigned RATE_CO_W = 4;
  localparam int unsigned FORCE_W = 8;
  // timing
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned HALF_MS_NS = 500000;
  localparam int unsigned CYCLES_PER_MS = MS_NS / CLOCK_PERIOD_NS;
  localparam int unsigned CYCLES_PER_HALF_MS = HALF_MS_NS / CLOCK_PERIOD_NS;
  typedef enum logic [3:0] {
    P_NONE, P_NODE_ADDR, P_RATE, P_CONN, P_FAULT, P_TIMEOUT,
    P_CO_ADDR, P_FORCE, P_DELAY, P_SYNC, P_PROFILE
  } param_id_t;
endpackage

// *** rtl/tick_gen.sv ***
// free-running prescaler giving a one-cycle tick every DIV clocks
// assumes i_restart comes from logic on the same clock
`timescale 1ns/1ps
module tick_gen #(
  parameter int unsigned DIV = 100000
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_restart,
  output logic o_tick
);
  localparam int unsigned CW = $clog2(DIV);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } tick_state_t;
  tick_state_t q, d;
  if (DIV < 2) begin : g_bad_div
    $error("tick_gen needs DIV of at least 2");
  end
  // restart realigns the phase so a delay starts from a clean boundary
  assign o_tick = (q.cnt == CW'(DIV - 1)) && !i_restart;
  always_comb begin
    d = q;
    if (i_restart || o_tick) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // tick_gen

// *** rtl/down_counter.sv ***
// loadable tick counter, pulses o_expired when the loaded count runs out
// assumes i_tick from a tick_gen restarted together with i_load
`timescale 1ns/1ps
module down_counter #(
  parameter int unsigned W = 16
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_load,
  input wire logic i_clear,
  input wire logic [W-1:0] i_value,
  input wire logic i_tick,
  output logic o_busy,
  output logic o_expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic expired;
  } cnt_state_t;
  cnt_state_t q, d;
  if (W < 1) begin : g_bad_w
    $error("down_counter needs W of at least 1");
  end
  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (i_clear) begin
      d.busy = 1'b0;
    end else if (i_load) begin
      // zero load expires at once instead of waiting a full wrap
      d.cnt = i_value;
      d.busy = (i_value != '0);
      d.expired = (i_value == '0);
    end else if (q.busy && i_tick) begin
      d.cnt = q.cnt - W'(1);
      if (q.cnt == W'(1)) begin
        d.busy = 1'b0;
        d.expired = 1'b1;
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign o_busy = q.busy;
  assign o_expired = q.expired;
endmodule // down_counter

// *** rtl/drive_fieldbus_comm_params.sv ***
// fieldbus communication parameter bank with timeout and response delay
// assumes access, fault and activity strobes are synchronous to i_clock;
// i_power_up marks the next power-on start that latches pending settings
`timescale 1ns/1ps
// Operation
// (RQ1) modbus node address accepts 1 to 247, factory 127
// (RQ2) addresses, rate and connection settings apply only at next power-up
// (RQ3) rate spans 0 to 405h, factory 102h; canopen writes touch canopen part
// (RQ4) connection settings accept 6h to 9h, factory 7h
// (RQ5) modbus fault raises alert when handling is 0, error when 1
// (RQ6) silence longer than monitoring time in ms raises timeout error
// (RQ7) monitoring time zero disables timeout supervision
// (RQ8) canopen node address holds 0 to 127
// (RQ9) forcing mask bits 0 to 7 permit forcing of inputs one to eight
// (RQ10) forcing needs the separate forcing value; the mask alone forces nothing
// (RQ11) each modbus response is delayed by count times 0.5 ms, count 0 to 1000
// (RQ12) sync settings span 1001h to 9FFFh, changeable only with power stage off
// (RQ13) profile activation 0 deactivates, 1 activates, factory 0
// (RQ14) modbus address and canopen index reach the same stored value
module drive_fieldbus_comm_params
  import comm_params_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS,
  parameter int unsigned HALF_MS_CYCLES = CYCLES_PER_HALF_MS
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic i_acc_canopen,
  input wire logic [15:0] i_acc_index,
  input wire logic [15:0] i_acc_wdata,
  output logic o_acc_done,
  output logic o_acc_refused,
  output logic [15:0] o_acc_rdata,
  input wire logic i_power_up,
  input wire logic i_power_stage_on,
  input wire logic i_modbus_fault,
  input wire logic i_comm_activity,
  input wire logic i_fault_reset,
  input wire logic i_resp_request,
  input wire logic [FORCE_W-1:0] i_input_forcing_value,
  output logic [15:0] o_modbus_node_addr,
  output logic [15:0] o_transmission_rate,
  output logic [15:0] o_conn_settings,
  output logic [15:0] o_canopen_node_addr,
  output logic [15:0] o_sync_settings,
  output logic o_profile_active,
  output logic [FORCE_W-1:0] o_force_permit,
  output logic [FORCE_W-1:0] o_forced_inputs,
  output logic o_comm_alert,
  output logic o_comm_error,
  output logic o_timeout_error,
  output logic o_resp_release
);
  typedef struct packed {
    logic [15:0] node_addr;
    logic [15:0] rate;
    logic [15:0] conn;
    logic [15:0] fault_mode;
    logic [15:0] timeout_ms;
    logic [15:0] co_addr;
    logic [15:0] force_mask;
    logic [15:0] delay;
    logic [15:0] sync;
    logic [15:0] profile;
    logic [15:0] act_node_addr;
    logic [15:0] act_rate;
    logic [15:0] act_conn;
    logic [15:0] act_co_addr;
    logic [15:0] rdata;
    logic done;
    logic refused;
    logic [FORCE_W-1:0] forced;
    logic alert;
    logic error;
    logic timeout_err;
  } bank_state_t;

  localparam bank_state_t RST_STATE = '{
    node_addr: RST_NODE_ADDR, rate: RST_RATE, conn: RST_CONN,
    fault_mode: RST_FAULT, timeout_ms: RST_TIMEOUT, co_addr: RST_CO_ADDR,
    force_mask: RST_FORCE, delay: RST_DELAY, sync: RST_SYNC,
    profile: RST_PROFILE, act_node_addr: RST_NODE_ADDR, act_rate: RST_RATE,
    act_conn: RST_CONN, act_co_addr: RST_CO_ADDR, rdata: 16'h0000,
    done: 1'b0, refused: 1'b0, forced: '0, alert: 1'b0, error: 1'b0,
    timeout_err: 1'b0
  };

  bank_state_t q, d;
  param_id_t acc_id;
  logic wr_en;
  logic wr_ok;
  logic [15:0] wval;
  logic wd_load;
  logic wd_clear;
  logic wd_tick;
  logic wd_expired;
  logic dly_tick;
  logic dly_busy;
  logic dly_expired;

  if (MS_CYCLES < 2 || HALF_MS_CYCLES < 2) begin : g_bad_timing
    $error("drive_fieldbus_comm_params needs tick periods of at least 2 cycles");
  end

  // both address spaces fold onto one id, so there is a single copy of each value
  function automatic param_id_t decode(input logic canopen, input logic [15:0] idx);
    param_id_t id;
    id = P_NONE;
    if (canopen) begin
      case (idx)
        CO_NODE_ADDR: id = P_NODE_ADDR;
        CO_RATE: id = P_RATE;
        CO_CONN: id = P_CONN;
        CO_FAULT: id = P_FAULT;
        CO_TIMEOUT: id = P_TIMEOUT;
        CO_CO_ADDR: id = P_CO_ADDR;
        CO_FORCE: id = P_FORCE;
        CO_DELAY: id = P_DELAY;
        CO_SYNC: id = P_SYNC;
        CO_PROFILE: id = P_PROFILE;
        default: id = P_NONE;
      endcase
    end else begin
      case (idx)
        MB_NODE_ADDR: id = P_NODE_ADDR;
        MB_RATE: id = P_RATE;
        MB_CONN: id = P_CONN;
        MB_FAULT: id = P_FAULT;
        MB_TIMEOUT: id = P_TIMEOUT;
        MB_CO_ADDR: id = P_CO_ADDR;
        MB_FORCE: id = P_FORCE;
        MB_DELAY: id = P_DELAY;
        MB_SYNC: id = P_SYNC;
        MB_PROFILE: id = P_PROFILE;
        default: id = P_NONE;
      endcase
    end
    return id;
  endfunction

  assign acc_id = decode(i_acc_canopen, i_acc_index); // [RQ14]
  assign wr_en = i_acc_valid && i_acc_write;

  // value to store and whether it lies in range; out of range leaves the old value
  always_comb begin
    wval = i_acc_wdata;
    wr_ok = 1'b0;
    case (acc_id)
      P_NODE_ADDR: wr_ok = (wval >= MIN_NODE_ADDR) && (wval <= MAX_NODE_ADDR); // [RQ1]
      P_RATE: begin
        if (i_acc_canopen) begin
          wval = q.rate; // [RQ3]
          wval[RATE_CO_LSB +: RATE_CO_W] = i_acc_wdata[RATE_CO_LSB +: RATE_CO_W]; // [RQ3]
        end
        wr_ok = (wval <= MAX_RATE); // [RQ3]
      end
      P_CONN: wr_ok = (wval >= MIN_CONN) && (wval <= MAX_CONN); // [RQ4]
      P_FAULT: wr_ok = (wval <= MAX_FLAG); // [RQ5]
      P_TIMEOUT: wr_ok = (wval <= MAX_TIMEOUT); // [RQ6]
      P_CO_ADDR: wr_ok = (wval <= MAX_CO_ADDR); // [RQ8]
      P_FORCE: wr_ok = (wval <= MAX_FORCE); // [RQ9]
      P_DELAY: wr_ok = (wval <= MAX_DELAY); // [RQ11]
      P_SYNC: wr_ok = (wval >= MIN_SYNC) && (wval <= MAX_SYNC) && !i_power_stage_on; // [RQ12]
      P_PROFILE: wr_ok = (wval <= MAX_FLAG); // [RQ13]
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.done = i_acc_valid;
    d.refused = i_acc_valid && (acc_id == P_NONE || (i_acc_write && !wr_ok));
    d.rdata = 16'h0000;
    if (i_acc_valid && !i_acc_write) begin
      case (acc_id)
        P_NODE_ADDR: d.rdata = q.node_addr;
        P_RATE: d.rdata = q.rate;
        P_CONN: d.rdata = q.conn;
        P_FAULT: d.rdata = q.fault_mode;
        P_TIMEOUT: d.rdata = q.timeout_ms;
        P_CO_ADDR: d.rdata = q.co_addr;
        P_FORCE: d.rdata = q.force_mask;
        P_DELAY: d.rdata = q.delay;
        P_SYNC: d.rdata = q.sync;
        P_PROFILE: d.rdata = q.profile;
        default: d.rdata = 16'h0000;
      endcase
    end
    if (wr_en && wr_ok) begin
      case (acc_id)
        P_NODE_ADDR: d.node_addr = wval;
        P_RATE: d.rate = wval;
        P_CONN: d.conn = wval;
        P_FAULT: d.fault_mode = wval;
        P_TIMEOUT: d.timeout_ms = wval;
        P_CO_ADDR: d.co_addr = wval;
        P_FORCE: d.force_mask = wval;
        P_DELAY: d.delay = wval;
        P_SYNC: d.sync = wval;
        P_PROFILE: d.profile = wval;
        default: d.profile = q.profile;
      endcase
    end
    // stored addresses, rate and connection settings reach the link logic only at the next power-on start
    if (i_power_up) begin
      d.act_node_addr = q.node_addr; // [RQ2]
      d.act_rate = q.rate; // [RQ2]
      d.act_conn = q.conn; // [RQ2]
      d.act_co_addr = q.co_addr; // [RQ2]
    end
    // forcing needs both the permission bit and the separately written value
    d.forced = q.force_mask[FORCE_W-1:0] & i_input_forcing_value; // [RQ9] [RQ10]
    // set beats clear so a fault in the reset cycle is not lost
    if (i_fault_reset) begin
      d.alert = 1'b0;
      d.error = 1'b0;
      d.timeout_err = 1'b0;
    end
    if (i_modbus_fault && q.fault_mode[0] == 1'b0) begin
      d.alert = 1'b1; // [RQ5]
    end
    if (i_modbus_fault && q.fault_mode[0] == 1'b1) begin
      d.error = 1'b1; // [RQ5]
    end
    if (wd_expired && q.timeout_ms != 16'h0000) begin
      d.timeout_err = 1'b1; // [RQ6] [RQ7]
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // watchdog restarts on every bus activity; supervision only armed after the first
  assign wd_clear = (q.timeout_ms == 16'h0000); // [RQ7]
  assign wd_load = i_comm_activity && !wd_clear; // [RQ6]

  tick_gen #(.DIV(MS_CYCLES)) u_wd_tick (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_restart(wd_load),
    .o_tick(wd_tick)
  );

  down_counter #(.W(16)) u_wd_cnt (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_load(wd_load),
    .i_clear(wd_clear),
    .i_value(q.timeout_ms),
    .i_tick(wd_tick),
    .o_busy(),
    .o_expired(wd_expired)
  );

  // a new request restarts the delay; the master never overlaps requests anyway
  tick_gen #(.DIV(HALF_MS_CYCLES)) u_dly_tick (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_restart(i_resp_request),
    .o_tick(dly_tick)
  );

  down_counter #(.W(16)) u_dly_cnt (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_load(i_resp_request),
    .i_clear(1'b0),
    .i_value(q.delay),
    .i_tick(dly_tick),
    .o_busy(dly_busy),
    .o_expired(dly_expired)
  );

  assign o_resp_release = dly_expired; // [RQ11]
  assign o_acc_done = q.done;
  assign o_acc_refused = q.refused;
  assign o_acc_rdata = q.rdata;
  assign o_modbus_node_addr = q.act_node_addr;
  assign o_transmission_rate = q.act_rate;
  assign o_conn_settings = q.act_conn;
  assign o_canopen_node_addr = q.act_co_addr;
  assign o_sync_settings = q.sync;
  assign o_profile_active = q.profile[0]; // [RQ13]
  assign o_force_permit = q.force_mask[FORCE_W-1:0]; // [RQ9]
  assign o_forced_inputs = q.forced;
  assign o_comm_alert = q.alert;
  assign o_comm_error = q.error;
  assign o_timeout_error = q.timeout_err;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  logic [7:0] rate_low;
  assign rate_low = q.rate[7:0];

  AST_NODE_ADDR_RANGE: assert property ( // [RQ1]
    q.node_addr >= MIN_NODE_ADDR && q.node_addr <= MAX_NODE_ADDR)
    else $error("modbus node address out of range");
  AST_ACTIVE_HOLD: assert property ( // [RQ2]
    !i_power_up |=> $stable(o_modbus_node_addr) && $stable(o_transmission_rate)
      && $stable(o_conn_settings) && $stable(o_canopen_node_addr))
    else $error("active setting changed without power-up");
  AST_RATE_CANOPEN_PART: assert property ( // [RQ3]
    (wr_en && i_acc_canopen && acc_id == P_RATE) |=> $stable(rate_low) && q.rate <= MAX_RATE)
    else $error("canopen rate write touched modbus part");
  AST_CONN_RANGE: assert property ( // [RQ4]
    q.conn >= MIN_CONN && q.conn <= MAX_CONN)
    else $error("connection settings out of range");
  AST_FAULT_ROUTE: assert property ( // [RQ5]
    (i_modbus_fault && !i_fault_reset) |=> ($past(q.fault_mode[0]) ? o_comm_error : o_comm_alert))
    else $error("modbus fault not reported per handling mode");
  AST_TIMEOUT_CAUSE: assert property ( // [RQ6]
    $rose(o_timeout_error) |-> $past(wd_expired) && $past(q.timeout_ms) != 16'h0000)
    else $error("timeout error without watchdog expiry");
  AST_TIMEOUT_OFF: assert property ( // [RQ7]
    (q.timeout_ms == 16'h0000 && !o_timeout_error) |=> !o_timeout_error)
    else $error("timeout raised while supervision disabled");
  AST_CO_ADDR_RANGE: assert property ( // [RQ8]
    q.co_addr <= MAX_CO_ADDR)
    else $error("canopen node address out of range");
  AST_FORCE_GATED: assert property ( // [RQ10]
    ##1 o_forced_inputs == ($past(o_force_permit) & $past(i_input_forcing_value)))
    else $error("input forced without permission and value");
  AST_DELAY_ZERO: assert property ( // [RQ11]
    (i_resp_request && q.delay == 16'h0000) |=> o_resp_release)
    else $error("zero response delay not released next cycle");
  AST_DELAY_WAIT: assert property ( // [RQ11]
    (i_resp_request && q.delay != 16'h0000) |=> !o_resp_release [*2])
    else $error("response released before half-ms delay");
  AST_SYNC_LOCKED: assert property ( // [RQ12]
    i_power_stage_on |=> $stable(q.sync) && q.sync >= MIN_SYNC && q.sync <= MAX_SYNC)
    else $error("sync settings changed with power stage on");
  AST_PROFILE_FLAG: assert property ( // [RQ13]
    q.profile <= MAX_FLAG)
    else $error("profile activation out of range");
  AST_SHARED_READ: assert property ( // [RQ14]
    (i_acc_valid && !i_acc_write && acc_id == P_SYNC && !(wr_en)) |=> o_acc_rdata == $past(q.sync))
    else $error("read data differs from stored value");

  COV_CANOPEN_RATE: cover property (wr_en && i_acc_canopen && acc_id == P_RATE && wr_ok);
  COV_TIMEOUT: cover property ($rose(o_timeout_error));
  COV_DELAYED_RESPONSE: cover property (dly_busy ##1 o_resp_release);
  COV_SYNC_REFUSED: cover property (wr_en && acc_id == P_SYNC && i_power_stage_on);
endmodule // drive_fieldbus_comm_params

// *** testbench/fieldbus_master_model.sv ***
// fieldbus master model: issues parameter accesses and holds the forcing value
// assumes the bank answers each one-cycle request with a done pulse one cycle later
`timescale 1ns/1ps
module fieldbus_master_model (
  input wire logic i_clock,
  input wire logic i_done,
  input wire logic i_refused,
  input wire logic [15:0] i_rdata,
  output logic o_valid,
  output logic o_write,
  output logic o_canopen,
  output logic [15:0] o_index,
  output logic [15:0] o_wdata,
  output logic [7:0] o_force_value
);
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_canopen = 1'b0;
    o_index = 16'h0000;
    o_wdata = 16'h0000;
    o_force_value = 8'h00;
  end
  // one access; caller picks address space, direction, index and write data
  task automatic xfer(input logic co, input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd, output logic rf, output logic ok);
    @(negedge i_clock);
    o_valid = 1'b1;
    o_write = wr;
    o_canopen = co;
    o_index = idx;
    o_wdata = wd;
    @(negedge i_clock);
    ok = i_done;
    rd = i_rdata;
    rf = i_refused;
    o_valid = 1'b0;
    // stale qualifiers inverted so nothing relies on them
    o_index = ~idx;
    o_wdata = ~wd;
  endtask
  // forcing only starts once this value is written
  task automatic set_force(input logic [7:0] v);
    @(negedge i_clock);
    o_force_value = v;
  endtask
endmodule // fieldbus_master_model

// *** testbench/tb_top.sv ***
// self-checking bench for the communication parameter bank
// assumes the master model drives accesses; bench drives strobes at falling edges
`timescale 1ns/1ps
module tb_top;
  import comm_params_pkg::*;
  localparam int MS = 10;
  localparam int HM = 5;
  logic clock, nrst, valid, wr, co, done, refused, pu, stage, fault, act, frst, req;
  logic [15:0] idx, wd, rd, node, rate, conn, coad, sync;
  logic [7:0] fval, permit, forced;
  logic prof, alert, error, tmo, rel;
  int err_total = 0;
  int cmp_count = 0;
  drive_fieldbus_comm_params #(.MS_CYCLES(MS), .HALF_MS_CYCLES(HM)) u_drive_fieldbus_comm_params (
    .i_clock(clock), .i_nrst(nrst), .i_acc_valid(valid), .i_acc_write(wr), .i_acc_canopen(co),
    .i_acc_index(idx), .i_acc_wdata(wd), .o_acc_done(done), .o_acc_refused(refused), .o_acc_rdata(rd),
    .i_power_up(pu), .i_power_stage_on(stage), .i_modbus_fault(fault), .i_comm_activity(act),
    .i_fault_reset(frst), .i_resp_request(req), .i_input_forcing_value(fval),
    .o_modbus_node_addr(node), .o_transmission_rate(rate), .o_conn_settings(conn),
    .o_canopen_node_addr(coad), .o_sync_settings(sync), .o_profile_active(prof),
    .o_force_permit(permit), .o_forced_inputs(forced), .o_comm_alert(alert), .o_comm_error(error),
    .o_timeout_error(tmo), .o_resp_release(rel));
  fieldbus_master_model u_fieldbus_master_model (
    .i_clock(clock), .i_done(done), .i_refused(refused), .i_rdata(rd), .o_valid(valid),
    .o_write(wr), .o_canopen(co), .o_index(idx), .o_wdata(wd), .o_force_value(fval));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic c, input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic erf, input logic [15:0] erd);
    logic [15:0] r;
    logic f;
    logic ok;
    u_fieldbus_master_model.xfer(c, w, a, d, r, f, ok);
    chk(16'(ok), 16'h0001);
    chk(16'(f), 16'(erf));
    chk(r, erd);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  task automatic t_reset();
    acc(0, 0, MB_NODE_ADDR, 16'h0000, 0, 16'h007F);
    acc(0, 0, MB_RATE, 16'h0000, 0, 16'h0102);
    acc(0, 0, MB_CONN, 16'h0000, 0, 16'h0007);
    acc(0, 0, MB_FAULT, 16'h0000, 0, 16'h0000);
    acc(0, 0, MB_TIMEOUT, 16'h0000, 0, 16'h0000);
    acc(0, 0, MB_CO_ADDR, 16'h0000, 0, 16'h0000);
    acc(0, 0, MB_FORCE, 16'h0000, 0, 16'h0000);
    acc(0, 0, MB_DELAY, 16'h0000, 0, 16'h0000);
    acc(1, 0, CO_SYNC, 16'h0000, 0, 16'h5055);
    acc(1, 0, CO_PROFILE, 16'h0000, 0, 16'h0000);
    chk(16'(prof), 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_range();
    acc(0, 1, MB_NODE_ADDR, 16'h0000, 1, 16'h0000);
    acc(0, 1, MB_NODE_ADDR, 16'h00F8, 1, 16'h0000);
    acc(0, 1, MB_NODE_ADDR, 16'h00F7, 0, 16'h0000);
    acc(0, 1, MB_RATE, 16'h0406, 1, 16'h0000);
    acc(0, 1, MB_CONN, 16'h0005, 1, 16'h0000);
    acc(0, 1, MB_CONN, 16'h000A, 1, 16'h0000);
    for (int v = 6; v <= 9; v++) acc(0, 1, MB_CONN, 16'(v), 0, 16'h0000);
    acc(0, 1, MB_FAULT, 16'h0002, 1, 16'h0000);
    acc(0, 1, MB_TIMEOUT, 16'h4E21, 1, 16'h0000);
    acc(0, 1, MB_TIMEOUT, 16'h4E20, 0, 16'h0000);
    acc(0, 1, MB_CO_ADDR, 16'h0080, 1, 16'h0000);
    acc(0, 1, MB_CO_ADDR, 16'h007F, 0, 16'h0000);
    acc(0, 1, MB_DELAY, 16'h03E9, 1, 16'h0000);
    acc(0, 1, MB_PROFILE, 16'h0002, 1, 16'h0000);
    acc(0, 1, 16'h0410, 16'h0001, 1, 16'h0000);
    acc(0, 0, MB_NODE_ADDR, 16'h0000, 0, 16'h00F7);
    acc(1, 1, CO_CONN, 16'h000A, 1, 16'h0000);
    acc(1, 0, CO_NODE_ADDR, 16'h0000, 0, 16'h00F7);
    acc(1, 0, CO_CONN, 16'h0000, 0, 16'h0009);
    acc(1, 0, CO_FAULT, 16'h0000, 0, 16'h0000);
    acc(1, 0, CO_TIMEOUT, 16'h0000, 0, 16'h4E20);
    acc(1, 0, CO_CO_ADDR, 16'h0000, 0, 16'h007F);
    acc(1, 0, CO_FORCE, 16'h0000, 0, 16'h0000);
    $display("range test done");
  endtask
  task automatic t_powerup();
    chk(node, 16'h007F);
    chk(conn, 16'h0007);
    chk(coad, 16'h0000);
    pulse(pu);
    chk(node, 16'h00F7);
    chk(conn, 16'h0009);
    chk(coad, 16'h007F);
    $display("power-up test done");
  endtask
  task automatic t_canopen();
    acc(1, 1, CO_RATE, 16'h0345, 0, 16'h0000);
    acc(0, 0, MB_RATE, 16'h0000, 0, 16'h0302);
    chk(rate, 16'h0102);
    pulse(pu);
    chk(rate, 16'h0302);
    acc(1, 1, CO_DELAY, 16'h0002, 0, 16'h0000);
    acc(0, 0, MB_DELAY, 16'h0000, 0, 16'h0002);
    acc(1, 0, 16'h4308, 16'h0000, 1, 16'h0000);
    $display("canopen test done");
  endtask
  task automatic t_sync();
    stage = 1'b1;
    acc(0, 1, MB_SYNC, 16'h2000, 1, 16'h0000);
    chk(sync, 16'h5055);
    stage = 1'b0;
    acc(0, 1, MB_SYNC, 16'h1000, 1, 16'h0000);
    acc(1, 1, CO_SYNC, 16'h9FFF, 0, 16'h0000);
    chk(sync, 16'h9FFF);
    $display("sync test done");
  endtask
  task automatic t_fault();
    pulse(fault);
    chk(16'({alert, error}), 16'h0002);
    pulse(frst);
    chk(16'(alert), 16'h0000);
    acc(0, 1, MB_FAULT, 16'h0001, 0, 16'h0000);
    pulse(fault);
    chk(16'({alert, error}), 16'h0001);
    pulse(frst);
    $display("fault test done");
  endtask
  task automatic t_timeout();
    acc(0, 1, MB_TIMEOUT, 16'h0002, 0, 16'h0000);
    pulse(act);
    repeat (2 * MS) @(negedge clock);
    chk(16'(tmo), 16'h0000);
    @(negedge clock);
    chk(16'(tmo), 16'h0001);
    pulse(frst);
    acc(0, 1, MB_TIMEOUT, 16'h0000, 0, 16'h0000);
    pulse(act);
    repeat (4 * MS) @(negedge clock);
    chk(16'(tmo), 16'h0000);
    $display("timeout test done");
  endtask
  task automatic t_force();
    acc(0, 1, MB_FORCE, 16'h000F, 0, 16'h0000);
    chk(16'(permit), 16'h000F);
    chk(16'(forced), 16'h0000);
    u_fieldbus_master_model.set_force(8'hFF);
    repeat (2) @(negedge clock);
    chk(16'(forced), 16'h000F);
    acc(0, 1, MB_PROFILE, 16'h0001, 0, 16'h0000);
    chk(16'(prof), 16'h0001);
    $display("force test done");
  endtask
  task automatic t_resp();
    pulse(req);
    repeat (2 * HM - 1) @(negedge clock);
    chk(16'(rel), 16'h0000);
    @(negedge clock);
    chk(16'(rel), 16'h0001);
    @(negedge clock);
    chk(16'(rel), 16'h0000);
    acc(0, 1, MB_DELAY, 16'h0000, 0, 16'h0000);
    pulse(req);
    chk(16'(rel), 16'h0001);
    $display("response test done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // run needs about 200 cycles; the limit leaves wide margin
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  initial begin
    {nrst, pu, stage, fault, act, frst, req} = 7'h00;
    repeat (3) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    t_reset();
    t_range();
    t_powerup();
    t_canopen();
    t_sync();
    t_fault();
    t_timeout();
    t_force();
    t_resp();
    summarize();
  end
endmodule // tb_top
